// *** hdl/rxdfw_pkg.sv ***
/*
 Constants for the receive descriptor flags-and-length word block.
 Assumes 32-bit descriptor words and byte addressing of main memory.
*/
package rxdfw_pkg;
    localparam int unsigned FIRST_BIT = 31;
    localparam int unsigned LAST_BIT = 30;
    localparam int unsigned OWN_BIT = 29;
    localparam int unsigned QEND_BIT = 28;
    localparam int unsigned ZLEN_BIT = 23;
    localparam int unsigned LEN_MSB = 15;
    localparam logic [31:0] WORD_VALID_MASK = 32'hF080FFFF;
    localparam logic [31:0] NULL_PTR = 32'h00000000;
    localparam logic [31:0] DESC_BYTES = 32'h00000010;
    localparam logic [31:0] WORD_BYTES = 32'h00000004;
    localparam logic [1:0] W_NEXT = 2'h0;
    localparam logic [1:0] W_FLAGS = 2'h3;
    localparam logic [15:0] LEN_ZERO = 16'h0000;
    localparam logic [16:0] LEN_ZERO_W = 17'h00000;
    typedef enum logic [1:0] {
        RXDFW_SPAN_ONE,
        RXDFW_SPAN_FIRST,
        RXDFW_SPAN_LAST,
        RXDFW_SPAN_MID
    } rxdfw_span_t;
endpackage

// *** hdl/rxdfw_len_if.sv ***
/*
 Interface carrying the packet length budget between the main block and its
 byte-limit counter. Assumes a single clock domain.
*/
`timescale 1ns/1ps
interface rxdfw_len_if;
    logic load;
    logic [15:0] load_len;
    logic take;
    logic [15:0] take_len;
    logic [15:0] granted;
    logic [15:0] remaining;
    modport owner (output load, output load_len, output take, output take_len,
        input granted, input remaining);
    modport counter (input load, input load_len, input take, input take_len,
        output granted, output remaining);
endinterface

// *** hdl/rxdfw_budget.sv ***
/*
 Packet length budget: loaded from the packet length on a first buffer,
 clips each buffer's byte count so the packet never exceeds that length.
 Assumes one clock, asynchronous active-high reset.
*/
`timescale 1ns/1ps
module rxdfw_budget (
    input wire logic ref_clk,
    input wire logic reset,
    rxdfw_len_if.counter len
);
    import rxdfw_pkg::*;
    logic [15:0] remaining_q;

    always_comb begin
        len.granted = (len.take_len > remaining_q) ? remaining_q : len.take_len;
    end
    assign len.remaining = remaining_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            remaining_q <= LEN_ZERO;
        end else if (len.load) begin
            remaining_q <= len.load_len;
        end else if (len.take) begin
            remaining_q <= remaining_q - len.granted;
        end
    end
endmodule

// *** hdl/rxdfw_top.sv ***
/*
 Receive descriptor flags-and-length word interpreter. Takes fetched
 descriptor words, decides packet delimiting, zero-length handling, data
 truncation and queue walk, and builds the written-back flags word.
 Assumes the fetch engine presents one descriptor word per fetch strobe with
 its word index, and that data movement is reported per buffer.
*/
`timescale 1ns/1ps
// What this block does
// - Bit 31 set marks the buffer as the first of a packet.
// - Bit 30 set marks the buffer as the last of a packet.
// - Bit 29 on a first buffer gives ownership to the engine, cleared when done.
// - Bit 28 is set on the last buffer of the last packet in the queue.
// - Bit 23 set means no data is moved and a zero-byte packet is sent.
// - Bits 15:0 hold the packet length, honoured only on a first buffer.
// - Data beyond the packet length is dropped.
// - First and last flags together tell the packet span class.
// - A zero next pointer ends the queue and stops the chain walk.
// - A descriptor is four 32-bit words; only the next pointer and flags words are used, and only the flags word is written back.
module rxdfw_top (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic word_valid,
    input wire logic [1:0] word_index,
    input wire logic [31:0] word_data,
    input wire logic [31:0] desc_addr,
    input wire logic buf_done,
    input wire logic [15:0] buf_bytes,
    input wire logic pkt_done,
    output logic desc_ready,
    output logic addr_aligned,
    output logic pkt_first,
    output logic pkt_last,
    output logic engine_owned,
    output logic zero_len,
    output rxdfw_pkg::rxdfw_span_t span,
    output logic [15:0] move_bytes,
    output logic [15:0] pkt_remaining,
    output logic queue_end,
    output logic [31:0] next_addr,
    output logic [31:0] wb_word,
    output logic wb_valid,
    output logic stalled
);
    import rxdfw_pkg::*;

    // Budget in its own module so the clip stays one comparator and one subtract
    rxdfw_len_if len ();
    rxdfw_budget u_budget (
        .ref_clk(ref_clk),
        .reset(reset),
        .len(len)
    );

    logic [31:0] next_ptr_q;
    logic [31:0] flags_q;
    logic [31:0] first_word_q;
    logic [1:0] seen_q;
    logic ready_q;
    logic [15:0] move_q;
    logic [31:0] wb_q;
    logic wb_valid_q;
    logic stalled_q;
    logic [31:0] flags_clean;
    logic is_first;
    logic is_last;
    logic is_zero;
    logic [31:0] wb_d;

    // Reserved fields dropped on capture
    assign flags_clean = word_data & WORD_VALID_MASK;
    assign is_first = flags_q[FIRST_BIT];
    assign is_last = flags_q[LAST_BIT];
    assign is_zero = flags_q[ZLEN_BIT];

    // Next pointer and flags words tracked: both needed
    // A word fetched in the finishing cycle already belongs to the next descriptor,
    // so the fetch wins over the clear by pkt_done
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            seen_q <= 2'h0;
        end else if (pkt_done) begin
            seen_q[0] <= word_valid && word_index == W_NEXT;
            seen_q[1] <= word_valid && word_index == W_FLAGS;
        end else if (word_valid) begin
            if (word_index == W_NEXT) begin
                seen_q[0] <= 1'b1;
            end
            if (word_index == W_FLAGS) begin
                seen_q[1] <= 1'b1;
            end
        end
    end

    // Ready one cycle after the later of the two words; one word alone never suffices
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ready_q <= 1'b0;
        end else if (pkt_done) begin
            ready_q <= 1'b0;
        end else if (word_valid) begin
            ready_q <= (seen_q[0] || word_index == W_NEXT)
                && (seen_q[1] || word_index == W_FLAGS);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            next_ptr_q <= NULL_PTR;
        end else if (word_valid && word_index == W_NEXT) begin
            next_ptr_q <= word_data;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flags_q <= NULL_PTR;
        end else if (word_valid && word_index == W_FLAGS) begin
            flags_q <= flags_clean;
        end
    end

    // Packet length and ownership kept from the first buffer only
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            first_word_q <= NULL_PTR;
        end else if (word_valid && word_index == W_FLAGS && flags_clean[FIRST_BIT]) begin
            first_word_q <= flags_clean;
        end
    end

    assign len.load = word_valid && word_index == W_FLAGS && flags_clean[FIRST_BIT];
    assign len.load_len = flags_clean[LEN_MSB:0];
    // Zero-length buffers never draw on the budget
    assign len.take = buf_done && !is_zero;
    assign len.take_len = buf_bytes;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            move_q <= LEN_ZERO;
        end else if (buf_done) begin
            // A zero-length buffer still completes; it just moves nothing
            move_q <= is_zero ? LEN_ZERO : len.granted;
        end
    end

    // Budget exhausted before the last buffer
    // Reported only: later buffers of the packet move nothing, which is legal truncation
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            stalled_q <= 1'b0;
        end else if (len.load) begin
            stalled_q <= 1'b0;
        end else if (buf_done && !is_zero && !is_last) begin
            stalled_q <= ({1'b0, len.remaining} - {1'b0, len.granted}) == LEN_ZERO_W;
        end
    end

    // Write-back: owner cleared on first, queue end on last with null next
    // Software's own bit 28 is never echoed: only the engine may claim queue end
    always_comb begin
        wb_d = flags_q;
        if (is_first) begin
            wb_d[OWN_BIT] = 1'b0;
        end
        wb_d[QEND_BIT] = is_last && (next_ptr_q == NULL_PTR);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wb_q <= NULL_PTR;
        end else if (pkt_done && ready_q) begin
            wb_q <= wb_d;
        end
    end

    // Write-back strobe only for a complete descriptor
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wb_valid_q <= 1'b0;
        end else begin
            wb_valid_q <= pkt_done && ready_q;
        end
    end

    always_comb begin
        case ({is_first, is_last})
            2'b11: span = RXDFW_SPAN_ONE;
            2'b10: span = RXDFW_SPAN_FIRST;
            2'b01: span = RXDFW_SPAN_LAST;
            2'b00: span = RXDFW_SPAN_MID;
            default: span = RXDFW_SPAN_MID;
        endcase
    end

    assign desc_ready = ready_q;
    // Alignment reported, not enforced: the fetch engine owns the response
    assign addr_aligned = (desc_addr & (WORD_BYTES - 32'h00000001)) == NULL_PTR;

    // Flag views of the captured word
    assign pkt_first = is_first;
    assign pkt_last = is_last;
    assign engine_owned = first_word_q[OWN_BIT];
    assign zero_len = is_zero;

    // Byte accounting
    assign move_bytes = move_q;
    assign pkt_remaining = len.remaining;

    // Queue walk
    assign queue_end = ready_q && next_ptr_q == NULL_PTR;
    // Walk stops at a null pointer, else the next descriptor address
    assign next_addr = (next_ptr_q == NULL_PTR) ? NULL_PTR : next_ptr_q;

    // Write-back and status
    assign wb_word = wb_q;
    assign wb_valid = wb_valid_q;
    assign stalled = stalled_q;
endmodule

// *** tb/rxdfw_checker.sv ***
/* Port checker for rxdfw_top.
 Assumes one clock and an asynchronous active-high reset. */
`timescale 1ns/1ps
module rxdfw_checker
    import rxdfw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [31:0] desc_addr,
    input wire logic buf_done,
    input wire logic [15:0] buf_bytes,
    input wire logic pkt_done,
    input wire logic desc_ready,
    input wire logic addr_aligned,
    input wire logic pkt_first,
    input wire logic pkt_last,
    input wire logic zero_len,
    input wire rxdfw_pkg::rxdfw_span_t span,
    input wire logic [15:0] move_bytes,
    input wire logic queue_end,
    input wire logic [31:0] next_addr,
    input wire logic [31:0] wb_word,
    input wire logic wb_valid
);
    import rxdfw_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    align_flag_a: assert property (addr_aligned == (desc_addr[1:0] == 2'h0))
        else $error("alignment flag wrong");
    span_class_a: assert property (span == (pkt_first ? (pkt_last ? RXDFW_SPAN_ONE :
        RXDFW_SPAN_FIRST) : (pkt_last ? RXDFW_SPAN_LAST : RXDFW_SPAN_MID)))
        else $error("span class wrong");
    wb_cause_a: assert property (wb_valid |-> $past(pkt_done) && $past(desc_ready))
        else $error("write-back without cause");
    wb_owner_a: assert property (wb_valid && wb_word[31] |-> !wb_word[29])
        else $error("ownership not returned");
    wb_reserved_a: assert property (wb_valid |-> wb_word[27:24] == 4'h0
        && wb_word[22:16] == 7'h00) else $error("reserved bits written");
    qend_last_a: assert property (wb_valid && wb_word[28] |-> wb_word[30])
        else $error("queue end without last flag");
    qend_chain_a: assert property (queue_end == (desc_ready && next_addr == 32'h0))
        else $error("queue end mismatch");
    zero_move_a: assert property (buf_done && zero_len |=> move_bytes == 16'h0000)
        else $error("zero-length buffer moved data");
    clip_move_a: assert property (buf_done |=> move_bytes <= $past(buf_bytes))
        else $error("more bytes moved than offered");
endmodule
bind rxdfw_top rxdfw_checker i_chk (.*);

// *** tb/rxdfw_host.sv ***
/* Software-side model: lays a descriptor's next pointer and flags word on the fetch port.
 Assumes the bench calls send only after reset release. */
`timescale 1ns/1ps
module rxdfw_host (
    input wire logic ref_clk,
    output logic word_valid = 1'b0,
    output logic [1:0] word_index = 2'h0,
    output logic [31:0] word_data = 32'h0,
    output logic [31:0] desc_addr = 32'h0
);
    task automatic send(input logic [31:0] nxt, input logic [31:0] flags);
        @(posedge ref_clk);
        desc_addr <= desc_addr + 32'h00000010;
        word_valid <= 1'b1;
        word_index <= 2'h0;
        word_data <= nxt;
        @(posedge ref_clk);
        word_index <= 2'h3;
        word_data <= flags;
        @(posedge ref_clk);
        word_valid <= 1'b0;
        // Released bus must not look like stale data
        word_data <= ~flags;
        #1;
    endtask
endmodule

// *** tb/rxdfw_bench.sv ***
/* Self-checking bench for rxdfw_top.
 Assumes rxdfw_host drives the fetch port and the checker is bound. */
`timescale 1ns/1ps
module rxdfw_bench;
    import rxdfw_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic word_valid, buf_done = 1'b0, pkt_done = 1'b0;
    logic [1:0] word_index;
    logic [31:0] word_data, desc_addr, next_addr, wb_word;
    logic [15:0] buf_bytes = 16'h0000, move_bytes, pkt_remaining;
    logic desc_ready, addr_aligned, pkt_first, pkt_last, engine_owned, zero_len;
    logic queue_end, wb_valid, stalled;
    rxdfw_span_t span;
    rxdfw_span_t sp[4] = '{RXDFW_SPAN_MID, RXDFW_SPAN_LAST, RXDFW_SPAN_FIRST, RXDFW_SPAN_ONE};
    int error_cnt = 0;
    int comparisons = 0;
    rxdfw_host i_host (.*);
    rxdfw_top i_dut (.*);
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic buf_pulse(input logic [15:0] n);
        @(posedge ref_clk);
        buf_done <= 1'b1;
        buf_bytes <= n;
        @(posedge ref_clk);
        buf_done <= 1'b0;
        #1;
    endtask
    task automatic end_pkt;
        @(posedge ref_clk);
        pkt_done <= 1'b1;
        @(posedge ref_clk);
        pkt_done <= 1'b0;
        #1;
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        i_host.send(32'h0, 32'hE0000064);
        chk(span, RXDFW_SPAN_ONE);
        chk(engine_owned, 1);
        chk(queue_end, 1);
        chk(addr_aligned, 1);
        chk(desc_ready, 1'h1);
        chk(next_addr, 32'h00000000);
        chk(pkt_remaining, 16'h0064);
        buf_pulse(16'h0096);
        chk(move_bytes, 16'h0064);
        chk(pkt_remaining, 16'h0000);
        chk(stalled, 1'h0);
        end_pkt();
        chk(wb_valid, 1);
        chk(wb_word[31:28], 4'hD);
        chk(desc_ready, 1'h0);
        // Reserved bits set on purpose, nonzero next pointer
        for (int i = 0; i < 4; i++) begin
            i_host.send(32'h00000100, {i[1:0], 6'h2F, 8'h7F, 16'h0010});
            chk(span, sp[i]);
            chk(next_addr, 32'h00000100);
            chk(pkt_remaining, i[1] ? 16'h0010 : 16'h0000);
            chk(pkt_first, i[1]);
            chk(pkt_last, i[0]);
            chk(queue_end, 0);
            end_pkt();
            chk({wb_word[27:24], wb_word[22:16]}, 0);
            chk(wb_word[31:30], i[1:0]);
            chk(wb_word[28] | (wb_word[29] & i[1]), 0);
        end
        // Budget spent exactly on a first, non-last buffer: flagged as truncation
        i_host.send(32'h00000200, 32'hA0000020);
        buf_pulse(16'h0020);
        chk(move_bytes, 16'h0020);
        chk(stalled, 1'h1);
        end_pkt();
        chk(wb_word[31:28], 4'h8);
        i_host.send(32'h0, 32'hA0800040);
        chk(zero_len, 1);
        chk(stalled, 1'h0);
        chk(pkt_remaining, 16'h0040);
        buf_pulse(16'h0028);
        chk(move_bytes, 0);
        chk(pkt_remaining, 16'h0040);
        end_pkt();
        end_pkt();
        chk(wb_valid, 0);
        end_of_test();
    end
endmodule
